// ---- core/pbs_pkg.sv ----
// Purpose: shared constants and carriers for the pipelined burst sync memory
// Assumes: one clock, synchronous active-low reset, pins sampled on mclk except outEnable_n and sleepRequest
// Notes: sizes follow the 512K x 36 organisation
package pbs_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = DATA_W / LANES;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int READ_LAT = 2;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;

  typedef enum logic {SEL_IDLE, SEL_ACTIVE} pbs_sel_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic pipelinedChipSelect_n;
    logic depthSelectHigh;
    logic depthSelectLow_n;
    logic processorAddrStrobe_n;
    logic controllerAddrStrobe_n;
    logic burstAdvance_n;
    logic [LANES-1:0] laneWriteEnable_n;
    logic byteWriteQualify_n;
    logic allLanesWrite_n;
    logic linearMode;
  } pbs_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] mask;
  } pbs_wr_s;

  localparam int WR_W = $bits(pbs_wr_s);
endpackage : pbs_pkg

// ---- core/pbs_fifo.sv ----
// Purpose: small valid/ready buffer for pending array writes
// Assumes: one clock, synchronous active-low reset
// Notes: full and empty come from an occupancy count, so no pointer aliasing
module pbs_fifo
  import pbs_pkg::*;
#(
  parameter int WIDTH = WR_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("pbs_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [PTR_W:0] count_r, count_nxt;
  logic push, pop;

  assign inReady = (count_r != DEPTH[PTR_W:0]);
  assign outValid = (count_r != '0);
  assign outData = store[rdPtr_r];

  always_comb
  begin
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      store[wrPtr_r] <= inData;
    end
  end
endmodule : pbs_fifo

// ---- core/pbs_sram.sv ----
// Purpose: pipelined burst synchronous static memory with double-cycle deselect
// Assumes: pins synchronous to mclk; outEnable_n and sleepRequest act without sampling
// Notes: writes queue in a buffer and retire one per cycle while awake
module pbs_sram
  import pbs_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int NL = LANES,
  parameter int WB_DEPTH = FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire pbs_pins_s busIn,
  input wire logic outEnable_n,
  input wire logic sleepRequest,
  output logic [DW-1:0] dqOut,
  output logic dqOe,
  output logic writeBufReady
);
  if (AW != ADDR_W || DW != DATA_W || NL != LANES || DW % NL != 0)
  begin : g_bad_size
    $error("pbs_sram sizes must match the package carriers");
  end

  pbs_pins_s inReg_r;
  logic [DW-1:0] mem [2**AW];

  pbs_sel_e sel_r, sel_nxt;
  logic [AW-1:0] base_r, base_nxt;
  logic [BURST_W-1:0] start_r, start_nxt, count_r, count_nxt, countUse, curLow;
  logic [AW-1:0] curAddr;
  logic loadAddr, chipOn, procLoad, access, readIssue, writeIssue;
  logic [NL-1:0] wrMask;
  pbs_wr_s wrEntry, drainEntry;
  logic [WR_W-1:0] drainBits;
  logic fifoInReady, fifoOutValid, drainReady;
  logic [DW-1:0] merged;

  logic rdValid_r, rdValid_nxt, dqValid_r, dqValid_nxt, holdOe_r, holdOe_nxt;
  logic [DW-1:0] rdData_r, rdData_nxt, dq_r, dq_nxt;
  logic bufReady_r;

  // input registers: every synchronous pin lands here first
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      inReg_r <= '{addr: ADDR_RST, wrData: DATA_RST, depthSelectHigh: 1'b0,
                   laneWriteEnable_n: '1, linearMode: 1'b0, default: 1'b1};
    end
    else
    begin
      inReg_r <= busIn;
    end
  end

  // address load, burst counter and selection
  always_comb
  begin
    chipOn = !inReg_r.pipelinedChipSelect_n && inReg_r.depthSelectHigh
             && !inReg_r.depthSelectLow_n;
    // processor strobe is ignored while the pipelined select is off
    procLoad = !inReg_r.processorAddrStrobe_n && !inReg_r.pipelinedChipSelect_n;
    loadAddr = !sleepRequest && (procLoad || !inReg_r.controllerAddrStrobe_n);
    sel_nxt = sel_r;
    base_nxt = base_r;
    start_nxt = start_r;
    countUse = count_r;
    if (loadAddr)
    begin
      sel_nxt = chipOn ? SEL_ACTIVE : SEL_IDLE;
      base_nxt = inReg_r.addr;
      start_nxt = inReg_r.addr[BURST_W-1:0];
      countUse = BURST_RST;
    end
    else if (!inReg_r.burstAdvance_n && sel_r == SEL_ACTIVE && !sleepRequest)
    begin
      countUse = count_r + BURST_STEP;
    end
    count_nxt = countUse;
    // two-bit arithmetic wraps inside the aligned group of four
    curLow = inReg_r.linearMode ? start_nxt + countUse : start_nxt ^ countUse;
    curAddr = {base_nxt[AW-1:BURST_W], curLow};
    access = (sel_nxt == SEL_ACTIVE) && !sleepRequest;
  end

  // write lane selection; a processor-strobe load is never a write
  always_comb
  begin
    if (!inReg_r.allLanesWrite_n)
    begin
      wrMask = '1;
    end
    else if (!inReg_r.byteWriteQualify_n)
    begin
      wrMask = ~inReg_r.laneWriteEnable_n;
    end
    else
    begin
      wrMask = '0;
    end
    if (loadAddr && procLoad)
    begin
      wrMask = '0;
    end
    readIssue = access && (wrMask == '0);
    writeIssue = access && (wrMask != '0);
    wrEntry = '{addr: curAddr, data: inReg_r.wrData, mask: wrMask};
  end

  // a full buffer drops the write; writeBufReady mirrors not-full one cycle late
  pbs_fifo #(
    .WIDTH(WR_W),
    .DEPTH(WB_DEPTH)
  ) u_wbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(writeIssue),
    .inReady(fifoInReady),
    .inData(wrEntry),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .outData(drainBits)
  );

  // self-timed retirement, held while asleep; sleep also blocks new writes, so depth stays low
  always_comb
  begin
    drainReady = !sleepRequest;
    drainEntry = pbs_wr_s'(drainBits);
    for (int l = 0; l < NL; l++)
    begin
      merged[l*LANE_W +: LANE_W] = drainEntry.mask[l] ? drainEntry.data[l*LANE_W +: LANE_W]
                                                     : mem[drainEntry.addr][l*LANE_W +: LANE_W];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (fifoOutValid && drainReady)
    begin
      mem[drainEntry.addr] <= merged;
    end
  end

  // read pipeline: array stage, then output register
  always_comb
  begin
    rdValid_nxt = readIssue;
    rdData_nxt = readIssue ? mem[curAddr] : rdData_r;
    dqValid_nxt = rdValid_r;
    dq_nxt = rdValid_r ? rdData_r : dq_r;
    holdOe_nxt = dqValid_r;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sel_r <= SEL_IDLE;
      base_r <= ADDR_RST;
      start_r <= BURST_RST;
      count_r <= BURST_RST;
      rdValid_r <= 1'b0;
      rdData_r <= DATA_RST;
      dqValid_r <= 1'b0;
      dq_r <= DATA_RST;
      holdOe_r <= 1'b0;
      bufReady_r <= 1'b0;
    end
    else
    begin
      sel_r <= sel_nxt;
      base_r <= base_nxt;
      start_r <= start_nxt;
      count_r <= count_nxt;
      rdValid_r <= rdValid_nxt;
      rdData_r <= rdData_nxt;
      dqValid_r <= dqValid_nxt;
      dq_r <= dq_nxt;
      holdOe_r <= holdOe_nxt;
      bufReady_r <= fifoInReady;
    end
  end

  assign dqOut = dq_r;
  assign writeBufReady = bufReady_r;
  // gating is deliberately combinational so the enables act without a clock edge
  assign dqOe = (dqValid_r || holdOe_r) && !outEnable_n && !sleepRequest;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_capture;
    1'b1 |=> inReg_r == $past(busIn);
  endproperty
  a_capture: assert property (p_capture) else $error("input register missed a pin");

  property p_hold_base;
    !loadAddr |=> base_r == $past(base_r);
  endproperty
  a_hold_base: assert property (p_hold_base) else $error("address moved without strobe");

  property p_no_step;
    !loadAddr && inReg_r.burstAdvance_n |=> count_r == $past(count_r);
  endproperty
  a_no_step: assert property (p_no_step) else $error("burst stepped without advance");

  property p_linear;
    !loadAddr && !inReg_r.burstAdvance_n && access && inReg_r.linearMode
      |-> curLow == start_r + count_r + BURST_STEP;
  endproperty
  a_linear: assert property (p_linear) else $error("linear burst order wrong");

  property p_interleave;
    !loadAddr && !inReg_r.burstAdvance_n && access && !inReg_r.linearMode
      |-> curLow == (start_r ^ (count_r + BURST_STEP));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

  property p_group;
    !loadAddr |-> curAddr[AW-1:BURST_W] == base_r[AW-1:BURST_W];
  endproperty
  a_group: assert property (p_group) else $error("burst left its group");

  property p_write_queued;
    writeIssue && fifoInReady |=> fifoOutValid;
  endproperty
  a_write_queued: assert property (p_write_queued) else $error("write not queued");

  property p_lanes;
    writeIssue && inReg_r.allLanesWrite_n |-> wrEntry.mask == ~inReg_r.laneWriteEnable_n;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane mask wrong");

  property p_all_lanes;
    access && !inReg_r.allLanesWrite_n && !(loadAddr && procLoad) |-> wrEntry.mask == '1;
  endproperty
  a_all_lanes: assert property (p_all_lanes) else $error("global write missed a lane");

  property p_dcd;
    dqValid_r ##1 !dqValid_r |-> dqOe == (!outEnable_n && !sleepRequest);
  endproperty
  a_dcd: assert property (p_dcd) else $error("drivers released too early");

  property p_async_oe;
    dqOe |-> !outEnable_n && !sleepRequest;
  endproperty
  a_async_oe: assert property (p_async_oe) else $error("drivers on while disabled");

  property p_read_lat;
    readIssue |-> ##2 dqValid_r && dq_r == $past(rdData_r);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read latency wrong");

  c_burst_read: cover property (readIssue ##1 readIssue ##1 readIssue ##1 readIssue);
  c_write: cover property (writeIssue ##1 fifoOutValid);
  c_dcd: cover property (dqValid_r ##1 !dqValid_r && dqOe);
  c_buf_full: cover property (!fifoInReady);
endmodule : pbs_sram

// ---- test/pbs_bus_model.sv ----
// Purpose: processor-side driver of the memory pins
// Assumes: pins change on the falling edge of mclk, held until the next one
// Notes: address and write-data lines not qualified by a strobe or a write carry inverted junk, never stale values
module pbs_bus_model
  import pbs_pkg::*;
(
  input wire logic mclk,
  output pbs_pins_s busIn
);
  timeunit 1ns;
  timeprecision 100ps;

  initial busIn = '1;

  // one bus cycle; returns just after the capturing edge
  task automatic step(input pbs_pins_s p);
    @(negedge mclk);
    // address only means something under a strobe
    if (p.processorAddrStrobe_n && p.controllerAddrStrobe_n) p.addr = ~busIn.addr;
    if (p.allLanesWrite_n && p.byteWriteQualify_n) p.wrData = ~busIn.wrData;
    busIn = p;
    @(posedge mclk);
    #1;
  endtask : step
endmodule : pbs_bus_model

// ---- test/pbs_sram_tb_top.sv ----
// Purpose: self-checking bench for the burst memory against a word-array model
// Assumes: inputs move on the falling edge; first read word two edges after capture
// Notes: write buffer cannot fill while it drains one word per cycle, so only ready is seen after reset
module pbs_sram_tb_top
  import pbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic outEnable_n = 1'b0;
  logic sleepRequest = 1'b0;
  pbs_pins_s busIn;
  pbs_pins_s p;
  logic [DATA_W-1:0] dqOut;
  logic dqOe;
  logic writeBufReady;
  logic [ADDR_W-1:0] base;
  logic [DATA_W-1:0] mem [int];
  int err_count = 0;
  int samples_checked = 0;
  int seed = 85985;

  pbs_sram DUT (.mclk(mclk), .rst_n(rst_n), .busIn(busIn), .outEnable_n(outEnable_n),
    .sleepRequest(sleepRequest), .dqOut(dqOut), .dqOe(dqOe), .writeBufReady(writeBufReady));
  pbs_bus_model ctl (.mclk(mclk), .busIn(busIn));

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  task automatic chkw(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chkw

  task automatic chkf(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chkf

  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // selected-capable but unselected, nothing strobed
  function automatic pbs_pins_s idle();
    pbs_pins_s q;
    q = '1;
    q.depthSelectLow_n = 1'b0;
    q.linearMode = 1'b0;
    return q;
  endfunction : idle

  // kind 0 all lanes, 1 qualified lane picks, 2 lane picks without qualifier
  task automatic wr(input logic [ADDR_W-1:0] a, input int kind);
    logic [DATA_W-1:0] d;
    logic [LANES-1:0] en;
    logic [DATA_W-1:0] m;
    d = DATA_W'({$random(seed), $random(seed)});
    en = LANES'($random(seed));
    p = idle();
    p.addr = a;
    p.controllerAddrStrobe_n = 1'b0;
    p.pipelinedChipSelect_n = 1'b0;
    p.wrData = d;
    p.laneWriteEnable_n = ~en;
    p.allLanesWrite_n = (kind != 0);
    // global write must win even over a qualified partial lane pick
    p.byteWriteQualify_n = (kind == 0) ? en[0] : (kind != 1);
    if (kind == 0) en = '1;
    if (kind == 2) en = '0;
    for (int l = 0; l < LANES; l++)
      m[l*LANE_W +: LANE_W] = {LANE_W{en[l]}};
    mem[a] = (mem[a] & ~m) | (d & m);
    ctl.step(p);
    chkf(1'b1, writeBufReady);
  endtask : wr

  // susp: processor strobe load, then one cycle without advance
  task automatic burst(input logic [ADDR_W-1:0] a, input logic lin, input logic susp);
    logic [BURST_W-1:0] off;
    int n;
    p = idle();
    p.linearMode = lin;
    p.addr = a;
    p.pipelinedChipSelect_n = 1'b0;
    p.controllerAddrStrobe_n = susp;
    p.processorAddrStrobe_n = ~susp;
    ctl.step(p);
    for (int k = 0; k < 7; k++)
    begin
      p = idle();
      p.linearMode = lin;
      p.burstAdvance_n = (susp && k == 0) || k > 2;
      // stray processor strobe with chip select off must not reload
      p.processorAddrStrobe_n = (k != 1);
      p.controllerAddrStrobe_n = (k != 3);
      p.addr = ADDR_W'($random(seed));
      ctl.step(p);
      if (k >= 1 && k <= 4)
      begin
        n = susp ? ((k > 1) ? k - 2 : 0) : k - 1;
        off = lin ? a[1:0] + BURST_W'(n) : a[1:0] ^ BURST_W'(n);
        chkw(mem[{a[ADDR_W-1:2], off}], dqOut);
      end
      // async pins toggled mid-cycle, well clear of both edges
      if (k == 1 || k == 4)
      begin
        outEnable_n = (k == 1);
        sleepRequest = (k == 4);
        #0.3;
        chkf(1'b0, dqOe);
        outEnable_n = 1'b0;
        sleepRequest = 1'b0;
        #0.3;
      end
      if (k >= 4) chkf(k < 6, dqOe);
    end
  endtask : burst

  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    chkf(1'b0, dqOe);
    chkw('0, dqOut);
    chkf(1'b0, writeBufReady);
    @(negedge mclk);
    rst_n = 1'b1;
    ctl.step(idle());
    chkf(1'b1, writeBufReady);
    base = ADDR_W'($random(seed)) & ~ADDR_W'(3);
    for (int i = 0; i < 4; i++) wr(base + ADDR_W'(i), 0);
    for (int i = 0; i < 8; i++) wr(base + ADDR_W'(i % 4), i % 3);
    // processor-strobe load with write pins active is still a read
    p = idle();
    p.addr = base;
    p.pipelinedChipSelect_n = 1'b0;
    p.processorAddrStrobe_n = 1'b0;
    p.allLanesWrite_n = 1'b0;
    p.wrData = DATA_W'($random(seed));
    ctl.step(p);
    p = idle();
    p.controllerAddrStrobe_n = 1'b0;
    ctl.step(p);
    ctl.step(idle());
    chkw(mem[base], dqOut);
    repeat (2) ctl.step(idle());
    // a write strobed while asleep must leave the array alone
    @(negedge mclk);
    sleepRequest = 1'b1;
    p = idle();
    p.addr = base + ADDR_W'(1);
    p.pipelinedChipSelect_n = 1'b0;
    p.controllerAddrStrobe_n = 1'b0;
    p.allLanesWrite_n = 1'b0;
    p.wrData = DATA_W'($random(seed));
    ctl.step(p);
    ctl.step(idle());
    @(negedge mclk);
    sleepRequest = 1'b0;
    for (int m = 0; m < 8; m++) burst(base + ADDR_W'(m % 4), m[2], 1'b0);
    burst(base + ADDR_W'(2), 1'b1, 1'b1);
    burst(base + ADDR_W'(3), 1'b0, 1'b1);
    end_sim();
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (4000) @(posedge mclk);
    err_count++;
    end_sim();
  end
endmodule : pbs_sram_tb_top
